// >>> design/sfcd_defines.svh
// opcodes, byte counts, reset values and masks of the command decoder
`ifndef SFCD_DEFINES_SVH
`define SFCD_DEFINES_SVH
// ==========================================================================
// opcodes
`define SFCD_OP_WR_EN 8'h06
`define SFCD_OP_WR_DIS 8'h04
`define SFCD_OP_RD_SR1 8'h05
`define SFCD_OP_RD_SR2 8'h35
`define SFCD_OP_WR_SR 8'h01
`define SFCD_OP_PROG 8'h02
`define SFCD_OP_QPROG 8'h32
`define SFCD_OP_ERASE64 8'hD8
`define SFCD_OP_ERASE32 8'h52
`define SFCD_OP_ERASE4 8'h20
`define SFCD_OP_CHIP_A 8'hC7
`define SFCD_OP_CHIP_B 8'h60
`define SFCD_OP_SUSPEND 8'h75
`define SFCD_OP_RESUME 8'h7A
`define SFCD_OP_PDOWN 8'hB9
`define SFCD_OP_CRM_RESET 8'hFF
`define SFCD_OP_RELEASE 8'hAB
`define SFCD_OP_MFR_DEV 8'h90
`define SFCD_OP_UNIQUE 8'h4B
`define SFCD_OP_JEDEC 8'h9F
// ==========================================================================
// byte positions within an instruction (count of completed bytes)
`define SFCD_ADDR_LAST 4'h3
`define SFCD_DATA_FIRST 4'h4
`define SFCD_UID_FIRST 4'h5
`define SFCD_UID_LAST 4'hC
`define SFCD_WRSR_SHORT 4'h2
`define SFCD_WRSR_LONG 4'h3
// ==========================================================================
// reset values and erase / program spans (low address bits covered)
`define SFCD_NV1_RESET 6'h00
`define SFCD_NV2_RESET 2'h0
`define SFCD_SPAN_PAGE 21'h0000FF
`define SFCD_SPAN_4K 21'h000FFF
`define SFCD_SPAN_32K 21'h007FFF
`define SFCD_SPAN_64K 21'h00FFFF
`define SFCD_SPAN_ALL 21'h1FFFFF
`define SFCD_UNIT_SMALL 21'h001000
`define SFCD_UNIT_BIG 21'h010000
`endif

// >>> design/sfcd_pkg.sv
// types shared by the serial flash command decoder
package sfcd_pkg;
  // instruction framing phase
  typedef enum logic [1:0] {PH_IDLE, PH_OPCODE, PH_BODY, PH_IGNORE}
    sfcd_phase_t;
  // operation handed to the array sequencer
  typedef enum logic [3:0] {
    OPK_NONE, OPK_PROG, OPK_QPROG, OPK_ERASE4, OPK_ERASE32, OPK_ERASE64,
    OPK_CHIP, OPK_WRSR, OPK_SUSPEND, OPK_RESUME
  } sfcd_op_t;
endpackage : sfcd_pkg

// >>> design/sfcd_fifo.sv
// program data fifo with registered output stage
`timescale 1ns/100ps
module sfcd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  // ========================================================================
  // handshakes; pointers wrap because depth is a power of two
  // the output stage is one of the depth words, so count it as held
  assign in_ready_o = (cnt_q + (AW+1)'(out_valid_q)) != (AW+1)'(DEPTH);
  wire push = in_valid_i & in_ready_o;
  wire load = (cnt_q != '0) & (~out_valid_q | out_ready_i);
  assign out_valid_o = out_valid_q;
  assign out_data_o = out_data_q;
  // storage is not reset; pointers, count and output stage are
  always_ff @(posedge clock_i)
  begin
    if (push)
      mem_q[wr_q] <= in_data_i;
  end
  // pointers, count and output stage
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (load)
      begin
        rd_q <= rd_q + 1'b1;
        out_data_q <= mem_q[rd_q];
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
      if (load)
        out_valid_q <= 1'b1;
      else if (out_ready_i)
        out_valid_q <= 1'b0;
    end
  end
endmodule : sfcd_fifo

// >>> design/sfcd_protect.sv
// decodes block-protect fields into a protected range and checks overlap
`timescale 1ns/100ps
`include "sfcd_defines.svh"
module sfcd_protect (
  input wire logic small_unit_select_i,
  input wire logic bottom_select_i,
  input wire logic [2:0] protect_level_i,
  input wire logic [20:0] addr_i,
  input wire logic [20:0] span_i,
  output logic protected_o
);
  // ========================================================================
  // range size: 64KB << (level-1), or 4KB << (level-1) capped at 32KB
  wire none_p = protect_level_i == 3'b000;
  wire all_p = protect_level_i[2] & protect_level_i[1];
  wire [2:0] shift = (small_unit_select_i & protect_level_i[2]) ? 3'd3
                     : protect_level_i - 3'd1;
  wire [20:0] unit = small_unit_select_i ? `SFCD_UNIT_SMALL
                     : `SFCD_UNIT_BIG;
  wire [20:0] size_m = (unit << shift) - 21'h000001;
  // operation span, from its aligned start to its last byte
  wire [20:0] lo = addr_i & ~span_i;
  wire [20:0] hi = addr_i | span_i;
  // top range starts at 2MB minus size, bottom range ends at size-1
  wire hit = bottom_select_i ? (lo <= size_m) : (hi >= ~size_m);
  assign protected_o = ~none_p & (all_p | hit);
endmodule : sfcd_protect

// >>> design/sfcd_top.sv
// serial flash instruction front end: framing, decode, ids, status, protect
// Operation
// - select falling starts; first byte is opcode
// - input sampled on rising clock, msb first
// - select rising ends the instruction
// - reads may end after any bit
// - writes abandoned unless ended on byte boundary
// - while busy, only status reads accepted
// - returned bytes shifted msb first on output
// - status byte repeats while selected
// - ABh: three dummies, then device code repeating
// - 06h sets, 04h clears latch; 01h writes status
// - 32h: address, then nibble data on four lines
// - D8h 52h 20h erase take three address bytes
// - chip erase, suspend, resume, program, power-down
// - 90h gives manufacturer/device; 9Fh gives jedec bytes
// - 4Bh with four dummies returns 64-bit id
// - 05h low status byte, 35h high byte
// - large-unit protect: 1/32 to 1/2, or all
// - small-unit protect: 4KB to 32KB top/bottom
// - manufacturer, device and 16-bit jedec codes exposed
// - writes accepted only with write latch set
// - write latch cleared at reset and cycle end
// - protected addresses refuse program and erase
`timescale 1ns/100ps
`include "sfcd_defines.svh"
module sfcd_top import sfcd_pkg::*; #(
  parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h3C, // arbitrary value
  parameter logic [15:0] JEDEC_CODE = 16'h6B21, // arbitrary value
  parameter logic UID_FITTED = 1'b1,
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF // arbitrary
)(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] quad_line_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  input wire logic array_done_i,
  output logic op_valid_o,
  output sfcd_op_t op_kind_o,
  output logic [23:0] op_addr_o,
  output logic prog_abort_o,
  output logic prog_overrun_o,
  output logic prog_valid_o,
  output logic [7:0] prog_data_o,
  input wire logic prog_ready_i,
  output logic write_latch_o,
  output logic busy_o,
  output logic [2:0] protect_level_o,
  output logic bottom_select_o,
  output logic small_unit_select_o,
  output logic quad_enable_o,
  output logic power_down_o
);
  // ==========================================================================
  // pin synchronisers: clock and select three stages, data two, so data aligns with the edge stage
  logic sclk_s0_q, sclk_s1_q, sclk_s2_q;
  logic cs_s0_q, cs_s1_q, cs_s2_q;
  logic [3:0] io_s0_q, io_s1_q;
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      {sclk_s0_q, sclk_s1_q, sclk_s2_q} <= 3'h0;
      {cs_s0_q, cs_s1_q, cs_s2_q} <= 3'h7;
      io_s0_q <= 4'h0;
      io_s1_q <= 4'h0;
    end
    else
    begin
      {sclk_s0_q, sclk_s1_q, sclk_s2_q} <= {sclk_i, sclk_s0_q, sclk_s1_q};
      {cs_s0_q, cs_s1_q, cs_s2_q} <= {cs_n_i, cs_s0_q, cs_s1_q};
      io_s0_q <= quad_line_i;
      io_s1_q <= io_s0_q;
    end
  end
  // edges seen on the second and third stages only
  wire sclk_rise = sclk_s1_q & ~sclk_s2_q;
  wire sclk_fall = ~sclk_s1_q & sclk_s2_q;
  wire cs_fall = ~cs_s1_q & cs_s2_q;
  wire cs_rise = cs_s1_q & ~cs_s2_q;
  wire serial_in = io_s1_q[0];
  // ==========================================================================
  // framing state
  sfcd_phase_t phase_q;
  logic [2:0] bit_q;
  logic [3:0] byte_q;
  logic [7:0] sh_q, op_q, wr_lo_q, wr_hi_q, tx_byte_q;
  logic [23:0] addr_q;
  logic tx_en_q, sout_q, oe_q;
  logic write_latch_q, busy_q, pdown_q, overrun_q, pushed_q;
  logic [5:0] nv1_q;
  logic [1:0] nv2_q;
  logic op_valid_q, abort_q;
  sfcd_op_t op_kind_q;
  logic [23:0] op_addr_q;
  // status bytes: volatile latch and busy below the stored fields
  wire [7:0] sr1 = {nv1_q, write_latch_q, busy_q};
  wire [7:0] sr2 = {6'h00, nv2_q};
  wire in_body = phase_q == PH_BODY;
  wire active = sclk_rise & ~cs_s1_q & (phase_q == PH_OPCODE | in_body);
  wire first = phase_q == PH_OPCODE;
  // quad program data: two clocks per byte, upper nibble first, bit7 on line 3
  wire quad_data = in_body & (op_q == `SFCD_OP_QPROG)
                   & (byte_q >= `SFCD_DATA_FIRST);
  wire [2:0] bit_next = bit_q + (quad_data ? 3'd4 : 3'd1);
  wire byte_done = active & (bit_next == 3'd0);
  wire [7:0] rx_byte = quad_data ? {sh_q[3:0], io_s1_q}
                       : {sh_q[6:0], serial_in};
  wire [3:0] byte_next = (byte_q == 4'hF) ? byte_q : byte_q + 4'h1;
  wire [7:0] op_cur = first ? rx_byte : op_q;
  // ==========================================================================
  // opcode table: known codes and the byte index where read data starts
  logic op_known;
  logic [3:0] rd_first;
  always_comb
  begin
    op_known = 1'b1;
    rd_first = 4'hF;
    case (op_cur)
      `SFCD_OP_RD_SR1, `SFCD_OP_RD_SR2, `SFCD_OP_JEDEC:
        rd_first = 4'h1;
      `SFCD_OP_RELEASE, `SFCD_OP_MFR_DEV:
        rd_first = `SFCD_DATA_FIRST;
      `SFCD_OP_UNIQUE:
        rd_first = UID_FITTED ? `SFCD_UID_FIRST : 4'hF;
      `SFCD_OP_WR_EN, `SFCD_OP_WR_DIS, `SFCD_OP_WR_SR, `SFCD_OP_PROG,
      `SFCD_OP_QPROG, `SFCD_OP_ERASE64, `SFCD_OP_ERASE32, `SFCD_OP_ERASE4,
      `SFCD_OP_CHIP_A, `SFCD_OP_CHIP_B, `SFCD_OP_SUSPEND, `SFCD_OP_RESUME,
      `SFCD_OP_PDOWN, `SFCD_OP_CRM_RESET:
        op_known = 1'b1;
      default:
        op_known = 1'b0;
    endcase
  end
  wire is_status = (op_cur == `SFCD_OP_RD_SR1) | (op_cur == `SFCD_OP_RD_SR2);
  // busy passes status reads only; power-down passes only its release
  wire op_accept = op_known & (~busy_q | is_status)
                   & (~pdown_q | op_cur == `SFCD_OP_RELEASE);
  // ==========================================================================
  // next byte to return, chosen by opcode and index of the coming byte
  wire [2:0] uid_sel = 3'(`SFCD_UID_LAST - byte_next);
  wire [63:0] uid_sh = UNIQUE_ID >> {uid_sel, 3'b000};
  // the address byte is still in flight when the first id byte is chosen
  wire dev_first = byte_next[0]
                   ^ (byte_q == `SFCD_ADDR_LAST ? rx_byte[0] : addr_q[0]);
  logic [7:0] tx_d;
  always_comb
  begin
    tx_d = 8'h00;
    case (op_cur)
      `SFCD_OP_RD_SR1: tx_d = sr1;
      `SFCD_OP_RD_SR2: tx_d = sr2;
      `SFCD_OP_RELEASE: tx_d = DEV_CODE;
      `SFCD_OP_MFR_DEV: tx_d = dev_first ? DEV_CODE : MFR_CODE;
      `SFCD_OP_UNIQUE: tx_d = uid_sh[7:0];
      `SFCD_OP_JEDEC:
        if (byte_next == 4'h1)
          tx_d = MFR_CODE;
        else if (byte_next == 4'h2)
          tx_d = JEDEC_CODE[15:8];
        else if (byte_next == 4'h3)
          tx_d = JEDEC_CODE[7:0];
      default: tx_d = 8'h00;
    endcase
  end
  wire tx_en_d = (byte_next >= rd_first)
                 & (op_cur != `SFCD_OP_UNIQUE
                    | byte_next <= `SFCD_UID_LAST);
  // ==========================================================================
  // framing: select edges open and close, rising clock shifts in
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      phase_q <= PH_IDLE;
      bit_q <= 3'h0;
      byte_q <= 4'h0;
      sh_q <= 8'h00;
      op_q <= 8'h00;
    end
    else if (cs_rise)
      phase_q <= PH_IDLE;
    else if (cs_fall)
    begin
      phase_q <= PH_OPCODE;
      bit_q <= 3'h0;
      byte_q <= 4'h0;
    end
    else if (active)
    begin
      sh_q <= rx_byte;
      bit_q <= bit_next;
      if (byte_done)
        byte_q <= byte_next;
      if (byte_done & first)
      begin
        op_q <= rx_byte;
        phase_q <= op_accept ? PH_BODY : PH_IGNORE;
      end
    end
  end
  // return path: byte loaded at each byte end, bits driven on falling clock
  always_ff @(posedge clock_i)
  begin
    if (rst_i | cs_fall)
    begin
      tx_byte_q <= 8'h00;
      tx_en_q <= 1'b0;
    end
    else if (byte_done & (~first | op_accept))
    begin
      tx_byte_q <= tx_d;
      tx_en_q <= tx_en_d;
    end
  end
  // output released at select rise; stays released on ignored opcodes
  always_ff @(posedge clock_i)
  begin
    if (rst_i | cs_rise | cs_fall)
    begin
      sout_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else if (sclk_fall & ~cs_s1_q)
    begin
      sout_q <= tx_byte_q[3'd7 - bit_q];
      oe_q <= tx_en_q;
    end
  end
  // ==========================================================================
  // address and status data capture; address is high byte first
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      addr_q <= 24'h000000;
      wr_lo_q <= 8'h00;
      wr_hi_q <= 8'h00;
    end
    else if (byte_done & in_body)
    begin
      if (byte_q <= `SFCD_ADDR_LAST)
        addr_q <= {addr_q[15:0], rx_byte};
      if (byte_q == 4'h1)
        wr_lo_q <= rx_byte;
      if (byte_q == 4'h2)
        wr_hi_q <= rx_byte;
    end
  end
  // ==========================================================================
  // protection check against the operation's whole span
  wire is_prog = (op_q == `SFCD_OP_PROG) | (op_q == `SFCD_OP_QPROG);
  wire is_chip = (op_q == `SFCD_OP_CHIP_A) | (op_q == `SFCD_OP_CHIP_B);
  wire is_erase = (op_q == `SFCD_OP_ERASE4) | (op_q == `SFCD_OP_ERASE32)
                  | (op_q == `SFCD_OP_ERASE64);
  wire [20:0] span = is_chip ? `SFCD_SPAN_ALL
                     : (op_q == `SFCD_OP_ERASE64) ? `SFCD_SPAN_64K
                     : (op_q == `SFCD_OP_ERASE32) ? `SFCD_SPAN_32K
                     : (op_q == `SFCD_OP_ERASE4) ? `SFCD_SPAN_4K
                     : `SFCD_SPAN_PAGE;
  logic prot;
  sfcd_protect u_protect (
    .small_unit_select_i(nv1_q[4]),
    .bottom_select_i(nv1_q[3]),
    .protect_level_i(nv1_q[2:0]),
    .addr_i(addr_q[20:0]),
    .span_i(span),
    .protected_o(prot)
  );
  // ==========================================================================
  // program data path; a full fifo cannot stall the host, so it aborts
  wire push = byte_done & in_body & is_prog & (byte_q >= `SFCD_DATA_FIRST)
              & write_latch_q & ~prot;
  logic fifo_ready;
  sfcd_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i(rx_byte),
    .out_valid_o(prog_valid_o),
    .out_ready_i(prog_ready_i),
    .out_data_o(prog_data_o)
  );
  always_ff @(posedge clock_i)
  begin
    if (rst_i | cs_fall)
    begin
      overrun_q <= 1'b0;
      pushed_q <= 1'b0;
    end
    else if (push)
    begin
      pushed_q <= 1'b1;
      if (~fifo_ready)
        overrun_q <= 1'b1;
    end
  end
  // ==========================================================================
  // completion decode at select rise
  wire on_bound = bit_q == 3'h0;
  wire wr_ok = cs_rise & in_body & on_bound & write_latch_q;
  wire do_wrsr = wr_ok & (op_q == `SFCD_OP_WR_SR)
                 & (byte_q == `SFCD_WRSR_SHORT
                    | byte_q == `SFCD_WRSR_LONG);
  wire do_erase = wr_ok & ~prot & ((is_erase & byte_q >= `SFCD_DATA_FIRST)
                  | is_chip);
  wire do_prog = wr_ok & ~prot & ~overrun_q & is_prog
                 & (byte_q > `SFCD_DATA_FIRST);
  wire do_misc = cs_rise & in_body & on_bound & ((op_q == `SFCD_OP_SUSPEND)
                 | (op_q == `SFCD_OP_RESUME));
  wire do_cycle = do_wrsr | do_erase | do_prog;
  sfcd_op_t kind_d;
  always_comb
  begin
    case (op_q)
      `SFCD_OP_PROG: kind_d = OPK_PROG;
      `SFCD_OP_QPROG: kind_d = OPK_QPROG;
      `SFCD_OP_ERASE4: kind_d = OPK_ERASE4;
      `SFCD_OP_ERASE32: kind_d = OPK_ERASE32;
      `SFCD_OP_ERASE64: kind_d = OPK_ERASE64;
      `SFCD_OP_CHIP_A, `SFCD_OP_CHIP_B: kind_d = OPK_CHIP;
      `SFCD_OP_WR_SR: kind_d = OPK_WRSR;
      `SFCD_OP_SUSPEND: kind_d = OPK_SUSPEND;
      `SFCD_OP_RESUME: kind_d = OPK_RESUME;
      default: kind_d = OPK_NONE;
    endcase
  end
  // operation hand-off to the array sequencer
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      op_valid_q <= 1'b0;
      op_kind_q <= OPK_NONE;
      op_addr_q <= 24'h000000;
      abort_q <= 1'b0;
    end
    else
    begin
      op_valid_q <= do_cycle | do_misc;
      abort_q <= cs_rise & pushed_q & ~do_prog;
      if (do_cycle | do_misc)
      begin
        op_kind_q <= kind_d;
        op_addr_q <= addr_q;
      end
    end
  end
  // status state: set of busy wins over the done clear in the same cycle
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      write_latch_q <= 1'b0;
      busy_q <= 1'b0;
      pdown_q <= 1'b0;
      nv1_q <= `SFCD_NV1_RESET;
      nv2_q <= `SFCD_NV2_RESET;
    end
    else
    begin
      if (array_done_i)
      begin
        busy_q <= 1'b0;
        write_latch_q <= 1'b0;
      end
      if (do_cycle)
        busy_q <= 1'b1;
      if (cs_rise & in_body & op_q == `SFCD_OP_WR_EN)
        write_latch_q <= 1'b1;
      if (cs_rise & in_body & op_q == `SFCD_OP_WR_DIS)
        write_latch_q <= 1'b0;
      if (do_wrsr)
      begin
        nv1_q <= wr_lo_q[7:2];
        nv2_q <= (byte_q == `SFCD_WRSR_LONG) ? wr_hi_q[1:0] : 2'h0;
      end
      if (cs_rise & in_body & op_q == `SFCD_OP_PDOWN)
        pdown_q <= 1'b1;
      if (cs_rise & in_body & op_q == `SFCD_OP_RELEASE)
        pdown_q <= 1'b0;
    end
  end
  // ==========================================================================
  // outputs, all from flip-flops
  assign serial_out_o = sout_q;
  assign serial_out_oe_o = oe_q;
  assign op_valid_o = op_valid_q;
  assign op_kind_o = op_kind_q;
  assign op_addr_o = op_addr_q;
  assign prog_abort_o = abort_q;
  assign prog_overrun_o = overrun_q;
  assign write_latch_o = write_latch_q;
  assign busy_o = busy_q;
  assign protect_level_o = nv1_q[2:0];
  assign bottom_select_o = nv1_q[3];
  assign small_unit_select_o = nv1_q[4];
  assign quad_enable_o = nv2_q[1];
  assign power_down_o = pdown_q;
  // ==========================================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  chk_frame_start: assert property (
    cs_fall |=> phase_q == PH_OPCODE && byte_q == 4'h0 && bit_q == 3'h0)
    else $error("select fall did not open an instruction");
  chk_opcode_msb: assert property (
    byte_done && first |=> op_q == $past(rx_byte))
    else $error("opcode not captured msb first");
  chk_frame_end: assert property (
    cs_rise |=> phase_q == PH_IDLE && !serial_out_oe_o)
    else $error("select rise did not close the instruction");
  chk_partial_write: assert property (
    cs_rise && bit_q != 3'h0 |=> !op_valid_o)
    else $error("write issued off a byte boundary");
  chk_busy_ignore: assert property (
    byte_done && first && busy_q && !is_status |=> phase_q == PH_IGNORE)
    else $error("instruction accepted while busy");
  chk_status_repeat: assert property (
    byte_done && in_body && op_q == `SFCD_OP_RD_SR1
    |=> tx_en_q && tx_byte_q == $past(sr1))
    else $error("status byte not reloaded");
  chk_release_id: assert property (
    byte_done && in_body && op_q == `SFCD_OP_RELEASE
    && byte_q >= `SFCD_ADDR_LAST |=> tx_byte_q == DEV_CODE && tx_en_q)
    else $error("device code not returned");
  chk_latch_gate: assert property (
    op_valid_o && op_kind_o != OPK_SUSPEND && op_kind_o != OPK_RESUME
    |-> $past(write_latch_q, 1) && busy_q)
    else $error("write issued without latch");
  chk_latch_clear: assert property (
    array_done_i && !do_cycle |=> !write_latch_q ##1 !busy_q [*2])
    else $error("cycle end left latch or busy set");
  chk_unknown_quiet: assert property (
    phase_q == PH_IGNORE |-> !serial_out_oe_o)
    else $error("ignored opcode drove the output");
  cov_program: cover property (do_prog ##[1:20] prog_valid_o);
  cov_status_busy: cover property (busy_q && tx_en_q && serial_out_oe_o);
  cov_wrsr_long: cover property (do_wrsr && byte_q == `SFCD_WRSR_LONG);
endmodule : sfcd_top

// >>> verification/sfcd_host.sv
// host model driving clock, select and data lines of the decoder
`timescale 1ns/100ps
module sfcd_host (
  input wire logic clock_i,
  input wire logic miso_i,
  output logic sclk_o = 1'b0,
  output logic cs_n_o = 1'b1,
  output logic [3:0] quad_o = 4'h5
);
  // ========================================
  // link tasks; the clock stands low between frames
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick
  task automatic start();
    cs_n_o <= 1'b0;
    tick(8);
  endtask : start
  // n bits msb first, set while clock low, reply taken at the rise
  task automatic bits(input logic [7:0] tx, input int n,
    output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      quad_o[0] <= tx[i];
      tick(8);
      sclk_o <= 1'b1;
      rx[i] = miso_i;
      tick(8);
      sclk_o <= 1'b0;
    end
  endtask : bits
  // quad data: upper nibble first, bit 7 on line 3
  task automatic qbyte(input logic [7:0] tx);
    for (int i = 1; i >= 0; i--)
    begin
      quad_o <= tx[4*i +: 4];
      tick(8);
      sclk_o <= 1'b1;
      tick(8);
      sclk_o <= 1'b0;
    end
  endtask : qbyte
  // released lines flip so stale data never passes for a bit
  task automatic stop();
    tick(8);
    cs_n_o <= 1'b1;
    quad_o <= ~quad_o;
    tick(16);
  endtask : stop
endmodule : sfcd_host

// >>> verification/sfcd_bench.sv
// self-checking bench for the serial flash command decoder
`timescale 1ns/100ps
module sfcd_bench import sfcd_pkg::*;;
  localparam logic [7:0] MFR = 8'hA5, DEV = 8'h3E; // arbitrary values
  localparam logic [15:0] JID = 16'h7C42; // arbitrary value
  localparam logic [63:0] UID = 64'hF1E2D3C4B5A69788; // arbitrary value
  logic clock_i = 1'b0, rst_i = 1'b1, done = 1'b0, ready = 1'b0;
  logic hold = 1'b0, oe_seen = 1'b0, cs_d = 1'b1;
  logic sclk, cs_n, so, soe, opv, pv, wl, busy, ovr, pd;
  logic abt, qe, bsel, ssel;
  logic [3:0] quad;
  logic [7:0] pdata, rx, last_pd;
  logic [23:0] addr;
  logic [2:0] plev;
  sfcd_op_t kind;
  int bad_count = 0, compares = 0, ops = 0, aborts = 0, n;
  always #5 clock_i = ~clock_i;
  sfcd_top #(.MFR_CODE(MFR), .DEV_CODE(DEV), .JEDEC_CODE(JID),
    .UNIQUE_ID(UID)) sfcd_top_inst (.clock_i(clock_i), .rst_i(rst_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .quad_line_i(quad), .serial_out_o(so),
    .serial_out_oe_o(soe), .array_done_i(done), .op_valid_o(opv),
    .op_kind_o(kind), .op_addr_o(addr), .prog_abort_o(abt),
    .prog_overrun_o(ovr), .prog_valid_o(pv), .prog_data_o(pdata),
    .prog_ready_i(ready), .write_latch_o(wl), .busy_o(busy),
    .protect_level_o(plev), .bottom_select_o(bsel),
    .small_unit_select_o(ssel), .quad_enable_o(qe), .power_down_o(pd));
  // a released output floats to the pull-up level, never the stale bit
  sfcd_host sfcd_host_inst (.clock_i(clock_i),
    .miso_i(soe === 1'b1 ? so : 1'b1),
    .sclk_o(sclk), .cs_n_o(cs_n), .quad_o(quad));
  // ========================================
  // array side: ends each cycle at once unless a test holds it busy
  always @(posedge clock_i)
  begin
    done <= busy && !hold && !done;
    ops <= ops + (opv === 1'b1);
    aborts <= aborts + (abt === 1'b1);
    cs_d <= cs_n;
    if (cs_d && !cs_n) oe_seen <= 1'b0;
    else if (soe === 1'b1) oe_seen <= 1'b1;
    if (pv && ready) last_pd <= pdata;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %0h, expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("compares %0d, bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  // opcode, then n bytes of arg high first; frame left open on request
  task automatic send(input logic [7:0] op, input logic [31:0] arg,
    input int n, input bit open_f);
    sfcd_host_inst.start();
    sfcd_host_inst.bits(op, 8, rx);
    for (int k = n - 1; k >= 0; k--) sfcd_host_inst.bits(arg[8*k +: 8], 8, rx);
    if (!open_f) sfcd_host_inst.stop();
  endtask : send
  task automatic rd(input logic [7:0] exp);
    sfcd_host_inst.bits(8'h00, 8, rx);
    check(rx, exp);
  endtask : rd
  // bounded wait: a cycle that never ends closes the run
  task automatic idle();
    for (int k = 0; k < 40 && busy !== 1'b0; k++) @(posedge clock_i);
    if (busy !== 1'b0)
    begin
      bad_count++;
      test_done();
    end
  endtask : idle
  // ========================================
  // scenarios
  task automatic t_misc();
    send(8'h06, 0, 0, 0);
    send(8'h05, 0, 0, 1);
    rd(8'h02);
    rd(8'h02);
    sfcd_host_inst.stop();
    send(8'h35, 0, 0, 1);
    sfcd_host_inst.bits(8'h00, 3, rx);
    sfcd_host_inst.stop();
    send(8'h04, 0, 0, 0);
    check(wl, 1'b0);
    send(8'hFF, 32'hFF, 1, 0);
    send(8'h3D, 0, 2, 0);
    check(oe_seen, 1'b0);
    send(8'hB9, 0, 0, 0);
    check(pd, 1'b1);
  endtask : t_misc
  task automatic t_ids();
    send(8'hAB, 0, 3, 1);
    rd(DEV);
    rd(DEV);
    sfcd_host_inst.stop();
    check(pd, 1'b0);
    send(8'h9F, 0, 0, 1);
    rd(MFR);
    rd(JID[15:8]);
    rd(JID[7:0]);
    sfcd_host_inst.stop();
    send(8'h90, 0, 3, 1);
    rd(MFR);
    rd(DEV);
    sfcd_host_inst.stop();
    send(8'h4B, 0, 4, 1);
    for (int k = 7; k >= 0; k--) rd(UID[8*k +: 8]);
    sfcd_host_inst.stop();
  endtask : t_ids
  task automatic t_busy();
    send(8'h06, 0, 0, 0);
    hold <= 1'b1;
    send(8'h01, 32'h1402, 2, 0);
    send(8'h04, 0, 0, 0);
    check({wl, busy, kind}, {2'h3, OPK_WRSR});
    send(8'h05, 0, 0, 1);
    rd(8'h17);
    sfcd_host_inst.stop();
    hold <= 1'b0;
    idle();
    check({wl, ssel, bsel, plev, qe}, 7'h0B);
  endtask : t_busy
  task automatic t_erase();
    send(8'h06, 0, 0, 0);
    n = ops;
    send(8'h20, 32'h1F0000, 3, 0);
    check(ops, n);
    send(8'h06, 0, 0, 0);
    send(8'h20, 32'h012345, 3, 0);
    check({kind, addr}, {OPK_ERASE4, 24'h012345});
    idle();
    send(8'h06, 0, 0, 0);
    send(8'h52, 0, 3, 1);
    sfcd_host_inst.bits(8'h00, 3, rx);
    sfcd_host_inst.stop();
    check(ops, n + 1);
    send(8'hD8, 0, 3, 0);
    check(kind, OPK_ERASE64);
    idle();
  endtask : t_erase
  task automatic t_prog();
    send(8'h06, 0, 0, 0);
    n = ops;
    send(8'h02, 32'h0100, 3, 1);
    for (int k = 0; k < 9; k++) sfcd_host_inst.bits(k[7:0], 8, rx);
    check(ovr, 1'b1);
    sfcd_host_inst.stop();
    ready <= 1'b1;
    for (int k = 0; k < 20 && pv !== 1'b0; k++) @(posedge clock_i);
    check({pv, ops[15:0]}, {1'b0, n[15:0]});
    check(aborts, 1);
    send(8'h06, 0, 0, 0);
    send(8'h32, 32'h0200, 3, 1);
    sfcd_host_inst.qbyte(8'hC5);
    sfcd_host_inst.stop();
    check({kind, last_pd}, {OPK_QPROG, 8'hC5});
    idle();
  endtask : t_prog
  initial
  begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    check({wl, busy, soe}, 3'h0);
    t_misc();
    t_ids();
    t_busy();
    t_erase();
    t_prog();
    test_done();
  end
endmodule : sfcd_bench
